// File: ehm_top.sv
// Hard multiplier block with APB configuration and status registers.
//
// Summary of operation
// - Wide mode: one 18x18 full multiplier.
// - Narrow mode: two independent 9x9 multipliers.
// - Every operand and product path optionally registered.
// - Mixed signs; sign controls may be registered.
// - Narrow lanes share one sign per side.
// - High sign means signed; either makes signed.
// - All stages share clock, enable, clear.
// - Product sections: one 36 or two 18.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "ehm_cfg.svh"

module ehm_top (
	// APB clock and reset.
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave.
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output      logic                  pready,
	output      logic [31:0]           prdata,
	output      logic                  pslverr,
	// Fabric side: shared enable and clear.
	input  wire logic                  mult_ena,
	input  wire logic                  mult_clr_n,
	// Fabric side: operands and sign controls.
	input  wire logic [`EHM_OPW-1:0]   data_a,
	input  wire logic [`EHM_OPW-1:0]   data_b,
	input  wire logic                  sign_a,
	input  wire logic                  sign_b,
	// Fabric side: product.
	output      logic [`EHM_PRODW-1:0] product,
	output      logic                  product_signed
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	ehm_pkg::ehm_top_st_t st_ff;
	ehm_pkg::ehm_top_st_t nxt_st;
	ehm_pkg::ehm_opnd_t   opnd;
	ehm_pkg::ehm_prod_t   core_prod;
	logic                 core_clr_n;
	logic                 setup;
	logic                 access;
	logic                 mapped;
	logic                 ro_reg;
	logic [31:0]          rd_val;

	////////////////////////////////////////////////////////////////////////////
	// Fabric operands travel as one carrier into the core.
	always_comb begin
		opnd.a     = data_a;
		opnd.b     = data_b;
		opnd.signa = sign_a;
		opnd.signb = sign_b;
	end

	// Bus reset also clears the datapath, so no stale product survives it.
	assign core_clr_n = presetn & mult_clr_n;

	// Core holds all input and output stages on the one shared control set.
	ehm_core u_core (
		.clk   (pclk),
		.clr_n (core_clr_n),
		.ena   (mult_ena),
		.cfg   (st_ff.cfg),
		.opnd  (opnd),
		.prod  (core_prod)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus phase decode.
	assign setup  = psel & ~penable;
	assign access = psel & penable & st_ff.pready;

	// Address decode; unaligned and unknown offsets are not mapped.
	always_comb begin
		mapped = 1'b1;
		ro_reg = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			`EHM_CTRL_OFS: begin
				ro_reg = 1'b0;
				rd_val = {26'h000_0000, st_ff.cfg};
			end
			`EHM_STAT_OFS: begin
				rd_val[`EHM_STAT_MODE] = st_ff.cfg.mode;
				rd_val[`EHM_STAT_SGN]  = st_ff.res.sgn;
				rd_val[`EHM_STAT_ENA]  = st_ff.ena_seen;
			end
			`EHM_PLO_OFS: begin
				rd_val = st_ff.res.p[31:0];
			end
			`EHM_PHI_OFS: begin
				rd_val = {28'h000_0000, st_ff.res.p[`EHM_PRODW-1:32]};
			end
			`EHM_CNT_OFS: begin
				rd_val = st_ff.cnt;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the bus slave and the result port.
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.pready  = 1'b0;
		nxt_st.pslverr = 1'b0;

		// Answer in the first access cycle; data and error are fixed in setup.
		if (setup) begin
			nxt_st.pready  = 1'b1;
			nxt_st.pslverr = ~mapped | (pwrite & ro_reg);
			nxt_st.prdata  = pwrite ? 32'h0000_0000 : (mapped ? rd_val : 32'h0000_0000);
		end

		// Control writes land only at the completing edge, low byte lane only.
		if (access && pwrite && mapped && !ro_reg && pstrb[0]) begin
			nxt_st.cfg.mode    = ehm_pkg::ehm_mode_t'(pwdata[`EHM_CTRL_MODE]);
			nxt_st.cfg.reg_a   = pwdata[`EHM_CTRL_REGA];
			nxt_st.cfg.reg_b   = pwdata[`EHM_CTRL_REGB];
			nxt_st.cfg.reg_sa  = pwdata[`EHM_CTRL_REGSA];
			nxt_st.cfg.reg_sb  = pwdata[`EHM_CTRL_REGSB];
			nxt_st.cfg.reg_out = pwdata[`EHM_CTRL_REGOUT];
		end

		// The port register always samples, keeping outputs glitch-free at the cost of one cycle.
		nxt_st.res      = core_prod;
		nxt_st.ena_seen = mult_ena;

		// Count enabled cycles; wraps silently, software takes differences.
		if (mult_ena) begin
			nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Single state register for the whole top level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff          <= '0;
			st_ff.cfg      <= ehm_pkg::ehm_cfg_t'(`EHM_CTRL_RST);
			st_ff.cnt      <= `EHM_CNT_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register.
	assign pready         = st_ff.pready;
	assign prdata         = st_ff.prdata;
	assign pslverr        = st_ff.pslverr;
	assign product        = st_ff.res.p;
	assign product_signed = st_ff.res.sgn;

endmodule : ehm_top

// File: ehm_cfg.svh
// Offsets, field positions, reset values and widths of the hard multiplier block.
`ifndef EHM_CFG_SVH
`define EHM_CFG_SVH

// Register byte offsets on the APB side.
`define EHM_CTRL_OFS    8'h00
`define EHM_STAT_OFS    8'h04
`define EHM_PLO_OFS     8'h08
`define EHM_PHI_OFS     8'h0c
`define EHM_CNT_OFS     8'h10

// Control field positions.
`define EHM_CTRL_MODE   0
`define EHM_CTRL_REGA   1
`define EHM_CTRL_REGB   2
`define EHM_CTRL_REGSA  3
`define EHM_CTRL_REGSB  4
`define EHM_CTRL_REGOUT 5
`define EHM_CTRL_W      6

// Status field positions.
`define EHM_STAT_MODE   0
`define EHM_STAT_SGN    1
`define EHM_STAT_ENA    2

// Reset values.
`define EHM_CTRL_RST    6'h00
`define EHM_CNT_RST     32'h0000_0000

// Datapath widths.
`define EHM_OPW         18
`define EHM_NOPW        9
`define EHM_PRODW       36
`define EHM_NPRODW      18

`endif

// File: ehm_pkg.sv
// Types shared by the hard multiplier block and its core.
`include "ehm_cfg.svh"

package ehm_pkg;

	// Operating mode of the multiplier stage.
	typedef enum logic [0:0] {
		EHM_WIDE   = 1'b0,
		EHM_NARROW = 1'b1
	} ehm_mode_t;

	// Static configuration: mode and per-path register selects.
	typedef struct packed {
		logic      reg_out;
		logic      reg_sb;
		logic      reg_sa;
		logic      reg_b;
		logic      reg_a;
		ehm_mode_t mode;
	} ehm_cfg_t;

	// Operands and sign controls from the fabric.
	typedef struct packed {
		logic [`EHM_OPW-1:0] a;
		logic [`EHM_OPW-1:0] b;
		logic                signa;
		logic                signb;
	} ehm_opnd_t;

	// Product with its sign marker.
	typedef struct packed {
		logic [`EHM_PRODW-1:0] p;
		logic                  sgn;
	} ehm_prod_t;

	// Core state: input and output register stages.
	typedef struct packed {
		ehm_opnd_t in;
		ehm_prod_t out;
	} ehm_core_st_t;

	// Top state: bus slave, configuration and result port registers.
	typedef struct packed {
		ehm_cfg_t  cfg;
		logic      pready;
		logic      pslverr;
		logic [31:0] prdata;
		ehm_prod_t res;
		logic      ena_seen;
		logic [31:0] cnt;
	} ehm_top_st_t;

endpackage : ehm_pkg

// File: ehm_core.sv
// Multiplier stage with optional input and output registers.
`timescale 1ns/1ns
`include "ehm_cfg.svh"

module ehm_core (
	// Clock, shared enable and shared asynchronous clear.
	input  wire logic              clk,
	input  wire logic              clr_n,
	input  wire logic              ena,
	// Configuration.
	input  wire ehm_pkg::ehm_cfg_t  cfg,
	// Operands and product.
	input  wire ehm_pkg::ehm_opnd_t opnd,
	output      ehm_pkg::ehm_prod_t prod
);

	////////////////////////////////////////////////////////////////////////////
	ehm_pkg::ehm_core_st_t st_ff;
	ehm_pkg::ehm_core_st_t nxt_st;
	ehm_pkg::ehm_opnd_t    op;
	ehm_pkg::ehm_prod_t    mul;
	logic signed [`EHM_OPW*2+1:0]    wide_p;
	logic [`EHM_PRODW-1:0]           narrow_p;

	// Each operand and sign control picks its register or the live input alone.
	always_comb begin
		op.a     = cfg.reg_a  ? st_ff.in.a     : opnd.a;
		op.b     = cfg.reg_b  ? st_ff.in.b     : opnd.b;
		op.signa = cfg.reg_sa ? st_ff.in.signa : opnd.signa;
		op.signb = cfg.reg_sb ? st_ff.in.signb : opnd.signb;
	end

	// Wide mode: one full multiply; a high sign control extends the sign bit.
	assign wide_p = $signed({op.signa & op.a[`EHM_OPW-1], op.a}) *
	                $signed({op.signb & op.b[`EHM_OPW-1], op.b});

	// Narrow mode: two independent lanes sharing one sign control per operand side.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_lane
			logic [`EHM_NOPW-1:0]    la;
			logic [`EHM_NOPW-1:0]    lb;
			logic signed [2*`EHM_NOPW+1:0] lp;
			assign la = op.a[gi*`EHM_NOPW +: `EHM_NOPW];
			assign lb = op.b[gi*`EHM_NOPW +: `EHM_NOPW];
			assign lp = $signed({op.signa & la[`EHM_NOPW-1], la}) *
			            $signed({op.signb & lb[`EHM_NOPW-1], lb});
			assign narrow_p[gi*`EHM_NPRODW +: `EHM_NPRODW] = lp[`EHM_NPRODW-1:0];
		end
	endgenerate

	// Mode select; the product is signed when either operand is.
	always_comb begin
		mul.p   = (cfg.mode == ehm_pkg::EHM_NARROW) ? narrow_p : wide_p[`EHM_PRODW-1:0];
		mul.sgn = op.signa | op.signb;
	end

	// Stages load only while the shared enable is high and otherwise hold.
	always_comb begin
		nxt_st = st_ff;
		if (ena) begin
			nxt_st.in  = opnd;
			nxt_st.out = mul;
		end
	end

	// One clock, one enable and one clear feed every stage register.
	always_ff @(posedge clk or negedge clr_n) begin
		if (!clr_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Output section is registered or bypassed on its own.
	assign prod = cfg.reg_out ? st_ff.out : mul;

endmodule : ehm_core

// File: ehm_props.sv
// Port checker of the hard multiplier block.
`timescale 1ns/1ns
`include "ehm_cfg.svh"
module ehm_props (
	// Clock and reset.
	input wire logic                  pclk,
	input wire logic                  presetn,
	// Bus side.
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic                  pready,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	// Fabric side.
	input wire logic                  mult_ena,
	input wire logic                  mult_clr_n,
	input wire logic [`EHM_OPW-1:0]   data_a,
	input wire logic                  sign_a,
	input wire logic                  sign_b,
	input wire logic [`EHM_PRODW-1:0] product,
	input wire logic                  product_signed
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// A setup cycle is the request that the slave answers one cycle later.
	wire setup = psel && !penable;
	wire run = mult_ena && mult_clr_n;
	// Four quiet samples cover the deepest path of three edges, so old pipeline data has left.
	setup_answer_a: assert property (setup |=> pready) else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	unmapped_err_a: assert property (setup && paddr > 8'h10 |=> pslverr) else $error("unmapped accepted");
	ro_write_a: assert property (setup && pwrite && paddr != 8'h00 |=> pslverr) else $error("ro write ok");
	ctrl_read_a: assert property (setup && !pwrite && paddr == 8'h00 |=>
		!pslverr && prdata[31:6] == 26'h0) else $error("bad control read");
	unsigned_prod_a: assert property ((run && !sign_a && !sign_b) [*4] |=> !product_signed)
		else $error("unsigned marked signed");
	signed_prod_a: assert property ((run && sign_a) [*4] |=> product_signed) else $error("signed lost");
	zero_prod_a: assert property ((run && data_a == 18'h0) [*4] |=> product == 36'h0)
		else $error("zero operand nonzero");
	// Main scenarios.
	cover property (setup && pwrite && paddr == 8'h00);
	cover property (setup && paddr > 8'h10);
	cover property (run && sign_a && !sign_b);
endmodule : ehm_props
bind ehm_top ehm_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .mult_ena(mult_ena),
	.mult_clr_n(mult_clr_n), .data_a(data_a), .sign_a(sign_a), .sign_b(sign_b), .product(product),
	.product_signed(product_signed));

// File: ehm_fabric.sv
// Fabric-side model that feeds operands and sign controls.
`timescale 1ns/1ns
module ehm_fabric (
	// Clock.
	input wire logic         pclk,
	// Operands and sign controls.
	output     logic [17:0]  data_a,
	output     logic [17:0]  data_b,
	output     logic         sign_a,
	output     logic         sign_b
);
	logic [5:0] tick = 6'h0;
	initial {data_a, data_b, sign_a, sign_b} = 38'h0;
	// New operands and signs every cycle; one sign per side serves both narrow lanes.
	// Bursts of eight cycles with a zero unsigned A, or with A signed, so long quiet runs do occur.
	always @(posedge pclk) begin
		tick   <= tick + 6'h1;
		data_a <= (tick[5:3] == 3'h7) ? 18'h0 : 18'($urandom());
		data_b <= 18'($urandom());
		sign_a <= (tick[5:3] == 3'h3) | ((tick[5:3] != 3'h7) & 1'($urandom()));
		sign_b <= (tick[5:3] != 3'h7) & 1'($urandom());
	end
endmodule : ehm_fabric

// File: embedded_hard_multiplier_bench.sv
// Self-checking bench of the hard multiplier block.
`timescale 1ns/1ns
`include "ehm_cfg.svh"
module embedded_hard_multiplier_bench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, cfg;
	logic        pready, pslverr, sign_a, sign_b, product_signed;
	logic [17:0] data_a, data_b;
	logic [35:0] product;
	int          error_cnt = 0, total_checks = 0;
	logic        mult_ena = 1'b1, mult_clr_n = 1'b1;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] ena_edges = 32'h0;
	////////////////////////////////////////
	// Clock of 8 ns period.
	always #4 pclk = ~pclk;
	ehm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .mult_ena(mult_ena),
		.mult_clr_n(mult_clr_n), .data_a(data_a), .data_b(data_b), .sign_a(sign_a), .sign_b(sign_b),
		.product(product), .product_signed(product_signed));
	ehm_fabric fab (.pclk(pclk), .data_a(data_a), .data_b(data_b), .sign_a(sign_a), .sign_b(sign_b));
	// Enabled edges since reset; the count register must agree with this tally.
	always @(posedge pclk) begin
		if (presetn && mult_ena) ena_edges <= ena_edges + 32'h1;
	end
	// Reference product: sign-extend each operand as its control asks, keep the low bits.
	function automatic logic [36:0] model(input logic [17:0] a, b, input logic sa, sb, nar);
		logic [35:0] x, y;
		logic [17:0] p0, p1;
		x = {{18{sa & a[17]}}, a};
		y = {{18{sb & b[17]}}, b};
		p0 = {{9{sa & a[8]}}, a[8:0]} * {{9{sb & b[8]}}, b[8:0]};
		p1 = {{9{sa & a[17]}}, a[17:9]} * {{9{sb & b[17]}}, b[17:9]};
		return {sa | sb, nar ? {p1, p0} : 36'(x * y)};
	endfunction : model
	// Compare one result and count it.
	task automatic check(input logic [36:0] exp, got);
		total_checks++;
		if (exp !== got) begin
			error_cnt++;
			$display("mismatch at %0t exp %h got %h", $time, exp, got);
		end
	endtask : check
	// Print the verdict and end the run.
	task automatic report_and_stop();
		if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	// One bus transfer; ready and data are taken at the edge that samples ready high.
	task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd, rd, input logic err);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= adr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			report_and_stop();
		end
		check(37'(rd), 37'(prdata));
		check(37'(err), 37'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : bus
	// Random traffic against a stage model: each path reads its own register or the live input.
	// One random enable loads every stage at once; checks wait until both model stages hold real data.
	task automatic run(input logic [5:0] c);
		logic [37:0] in_q;
		logic [36:0] out_q, mul, exp;
		logic        go;
		int          fill;
		in_q = 38'h0;
		out_q = 37'h0;
		fill = 0;
		repeat (80) begin
			@(posedge pclk);
			mul = model(c[`EHM_CTRL_REGA] ? in_q[37:20] : data_a, c[`EHM_CTRL_REGB] ? in_q[19:2] : data_b,
				c[`EHM_CTRL_REGSA] ? in_q[1] : sign_a, c[`EHM_CTRL_REGSB] ? in_q[0] : sign_b, c[`EHM_CTRL_MODE]);
			exp = c[`EHM_CTRL_REGOUT] ? out_q : mul;
			go = (fill >= 2);
			if (mult_ena) begin
				in_q = {data_a, data_b, sign_a, sign_b};
				out_q = mul;
				fill++;
			end
			mult_ena <= (2'($urandom()) != 2'h0);
			#1;
			if (go) check(exp, {product_signed, product});
		end
	endtask : run
	// Enable low freezes every stage; the shared clear then empties them and spares the bus registers.
	task automatic hold_and_clear();
		logic [36:0] held;
		bus(1'b1, `EHM_CTRL_OFS, 32'h0000_003e, 32'h0, 1'b0);
		mult_ena <= 1'b1;
		repeat (3) @(posedge pclk);
		held = model(data_a, data_b, sign_a, sign_b, 1'b0);
		@(posedge pclk);
		mult_ena <= 1'b0;
		@(posedge pclk);
		bus(1'b0, `EHM_PLO_OFS, 32'h0, held[31:0], 1'b0);
		bus(1'b0, `EHM_PHI_OFS, 32'h0, {28'h0, held[35:32]}, 1'b0);
		bus(1'b0, `EHM_STAT_OFS, 32'h0, {29'h0, 1'b0, held[36], 1'b0}, 1'b0);
		bus(1'b0, `EHM_CNT_OFS, 32'h0, ena_edges, 1'b0);
		mult_clr_n <= 1'b0;
		@(posedge pclk);
		mult_clr_n <= 1'b1;
		#1;
		check(37'h0, {product_signed, product});
		bus(1'b0, `EHM_CTRL_OFS, 32'h0, 32'h0000_003e, 1'b0);
		bus(1'b0, `EHM_CNT_OFS, 32'h0, ena_edges, 1'b0);
	endtask : hold_and_clear
	// Main sequence: reset, refusals, each mode bypassed, registered and mixed, then hold and clear.
	initial begin
		void'($urandom(32'hd974));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		bus(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
		bus(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
		bus(1'b1, 8'h04, 32'h1, 32'h0, 1'b1);
		for (int i = 0; i < 6; i++) begin
			cfg = (i < 4) ? {26'h0, {5{i[1]}}, i[0]} : {26'h0, 6'($urandom())};
			bus(1'b1, 8'h00, cfg, 32'h0, 1'b0);
			bus(1'b0, 8'h00, 32'h0, cfg, 1'b0);
			run(cfg[5:0]);
		end
		// Byte lane 0 off: the control write is ignored without an error.
		pstrb <= 4'he;
		bus(1'b1, 8'h00, ~cfg, 32'h0, 1'b0);
		pstrb <= 4'hf;
		bus(1'b0, 8'h00, 32'h0, cfg, 1'b0);
		hold_and_clear();
		report_and_stop();
	end
endmodule : embedded_hard_multiplier_bench
